// File: hw/rpsb_pkg.sv
/*
 * Constants for the radio parameter and sleep/session bank: command codes,
 * reset values, field decodes and timing counts.
 * Assumes a single 250 MHz clock and a command decoder outside the bank.
 */
// Overview of operation
// - Level query returns one read-only byte, 0x06 to 0x36, larger is stronger
// - Line function 0 unused, 1 binary programming select, 2 flow-control input
// - Stop-bit parameter 0 gives one stop bit, 1 gives two; resets to 0
// - Unit number is two read-only 16-bit words, each returned as two bytes
// - Sleep mode 0 never, 1 pin, 3 to 8 cyclic 0.5 to 16 seconds
// - Sleep mode resets to 0 so the unit stays awake
// - Cyclic sleep wakes, listens, syncs on initializer or else sleeps again
// - Idle time counted in tenths; doze once it reaches the idle delay
// - Idle timer acts only in cyclic sleep, otherwise has no effect
// - By default every sent packet carries hopping sync information
// - Nonzero hold keeps session open that many 100 ms after last packet
// - Sync information returns only after the session has expired
// - Hold 0, the reset value, puts sync data in every packet
package rpsb_pkg;
	// Command codes
	localparam logic [7:0] CMD_DOZE_MODE     = 8'h01;
	localparam logic [7:0] CMD_LINE_FUNC     = 8'h16;
	localparam logic [7:0] CMD_KEEP_OPEN     = 8'h17;
	localparam logic [7:0] CMD_RX_LEVEL      = 8'h1C;
	localparam logic [7:0] CMD_UNIT_UPPER    = 8'h25;
	localparam logic [7:0] CMD_UNIT_LOWER    = 8'h26;
	localparam logic [7:0] CMD_FRAME_END     = 8'h36;
	// Reset values
	localparam logic [7:0] DOZE_MODE_RST     = 8'h00;
	localparam logic [7:0] LINE_FUNC_RST     = 8'h00;
	localparam logic [7:0] KEEP_OPEN_RST     = 8'h00;
	localparam logic [7:0] FRAME_END_RST     = 8'h00;
	localparam logic [7:0] RX_LEVEL_RST      = 8'h06;
	// Field values
	localparam logic [7:0] RX_LEVEL_MIN      = 8'h06;
	localparam logic [7:0] RX_LEVEL_MAX      = 8'h36;
	localparam logic [7:0] LINE_UNUSED       = 8'h00;
	localparam logic [7:0] LINE_BIN_PROG     = 8'h01;
	localparam logic [7:0] LINE_FLOW_CTRL    = 8'h02;
	localparam logic [7:0] FRAME_END_MAX     = 8'h01;
	localparam int         FRAME_END_BIT     = 0;
	localparam logic [7:0] DOZE_NEVER        = 8'h00;
	localparam logic [7:0] DOZE_PIN          = 8'h01;
	localparam logic [7:0] DOZE_CYC_FIRST    = 8'h03;
	localparam logic [7:0] DOZE_CYC_LAST     = 8'h08;
	// Cyclic wake periods in tenths of a second
	localparam logic [7:0] WAKE_T_0P5        = 8'h05;
	localparam logic [7:0] WAKE_T_1          = 8'h0A;
	localparam logic [7:0] WAKE_T_2          = 8'h14;
	localparam logic [7:0] WAKE_T_4          = 8'h28;
	localparam logic [7:0] WAKE_T_8          = 8'h50;
	localparam logic [7:0] WAKE_T_16         = 8'hA0;
	// Response lengths in bytes
	localparam logic [1:0] RSP_LEN_NONE      = 2'h0;
	localparam logic [1:0] RSP_LEN_BYTE      = 2'h1;
	localparam logic [1:0] RSP_LEN_WORD      = 2'h2;
	// Timing: one tenth of a second (also the 100 ms session unit)
	localparam int         CLK_PERIOD_NS     = 4;
	localparam int         TENTH_NS          = 100_000_000;
	localparam int         TENTH_CYCLES      = TENTH_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		RPSB_AWAKE  = 2'h0,
		RPSB_DOZE   = 2'h1,
		RPSB_LISTEN = 2'h3,
		RPSB_SYNC   = 2'h2
	} rpsb_state_e;
endpackage

// File: hw/rpsb_tick.sv
/*
 * Divider producing a one-cycle enable every CYCLES clocks.
 * Assumes the shared clock and synchronous active-low reset.
 */
`timescale 1ns/1ns
module rpsb_tick
	import rpsb_pkg::*;
#(
	parameter int CYCLES = TENTH_CYCLES
)
(
	input  logic clock,   // System clock
	input  logic resetn,  // Synchronous reset
	output logic tick_r   // One-cycle enable
);
	logic [31:0] count_r;

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			count_r <= 32'h0;
			tick_r  <= 1'b0;
		end
		else if (count_r == 32'(CYCLES - 1))
		begin
			count_r <= 32'h0;
			tick_r  <= 1'b1;
		end
		else
		begin
			count_r <= count_r + 32'h1;
			tick_r  <= 1'b0;
		end
	end
endmodule

// File: hw/rpsb_bank.sv
/*
 * Radio parameter bank: command port, line and framing decodes, sleep
 * controller with cyclic wake and idle timer, channel session hold timer.
 * Assumes commands arrive already parsed and synchronous to clock.
 */
`timescale 1ns/1ns
module rpsb_bank
	import rpsb_pkg::*;
#(
	parameter int          TICK_CYCLES = TENTH_CYCLES,
	parameter logic [15:0] UNIT_UPPER  = 16'h1234,  // Arbitrary value
	parameter logic [15:0] UNIT_LOWER  = 16'h5678   // Arbitrary value
)
(
	input  logic        clock,             // 250 MHz clock
	input  logic        resetn,            // Synchronous reset
	input  logic        cmd_valid,         // Command strobe
	input  logic        cmd_write,         // 1 write, 0 read
	input  logic [7:0]  cmd_code,          // Command code
	input  logic [15:0] cmd_wdata,         // Write parameter
	output logic        rsp_valid_r,       // Answer strobe
	output logic [15:0] rsp_data_r,        // Answer value
	output logic [1:0]  rsp_len_r,         // Answer byte count
	output logic        rsp_error_r,       // Unknown code, write to read-only code or bad value
	input  logic        rx_pkt,            // Packet received
	input  logic [7:0]  rx_level,          // Raw level of that packet
	input  logic        tx_pkt,            // Data packet about to be sent
	input  logic        tx_active,         // Transmitting
	input  logic        rx_active,         // Receiving
	input  logic [15:0] idle_delay_before_doze, // Tenths of a second
	input  logic        sleep_pin,         // Pin sleep request
	input  logic        wake_init_seen,    // Initializer detected
	input  logic        wake_init_done,    // Initializer finished
	output logic        bin_prog_en_r,     // Line is programming select
	output logic        flow_ctrl_en_r,    // Line is flow-control input
	output logic        two_stop_r,        // Two stop bits
	output logic        dozing_r,          // In sleep
	output logic        listening_r,       // Listening for initializer
	output logic        rx_start_r,        // Start receiving pulse
	output logic        session_open_r,    // Channel session open
	output logic        include_sync_r     // Send sync with this packet
);
	logic [7:0]  doze_mode_code;
	logic [7:0]  line_function_code;
	logic [7:0]  channel_keep_open_time;
	logic [7:0]  frame_end_bit_count;
	logic [7:0]  received_level_read;
	logic        tick;
	rpsb_state_e state_r;
	rpsb_state_e state_nxt;
	logic [15:0] idle_cnt_r;
	logic [7:0]  wake_cnt_r;
	logic [8:0]  sess_cnt_r;
	logic        cyclic;
	logic        activity;
	logic        wr;

	function automatic logic is_cyclic(input logic [7:0] m);
		return (m >= DOZE_CYC_FIRST) && (m <= DOZE_CYC_LAST);
	endfunction

	function automatic logic [7:0] wake_tenths(input logic [7:0] m);
		case (m)
			8'h03:   return WAKE_T_0P5;
			8'h04:   return WAKE_T_1;
			8'h05:   return WAKE_T_2;
			8'h06:   return WAKE_T_4;
			8'h07:   return WAKE_T_8;
			default: return WAKE_T_16;
		endcase
	endfunction

	function automatic logic [7:0] clamp_level(input logic [7:0] v);
		if (v < RX_LEVEL_MIN)
			return RX_LEVEL_MIN;
		else if (v > RX_LEVEL_MAX)
			return RX_LEVEL_MAX;
		else
			return v;
	endfunction

	rpsb_tick #(.CYCLES(TICK_CYCLES)) u_tick
	(
		.clock  (clock),
		.resetn (resetn),
		.tick_r (tick)
	);

	assign cyclic   = is_cyclic(doze_mode_code);
	assign activity = tx_active || rx_active;
	assign wr       = cmd_valid && cmd_write;

	// Writable parameters; out-of-range values are refused
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			doze_mode_code         <= DOZE_MODE_RST;
			line_function_code     <= LINE_FUNC_RST;
			channel_keep_open_time <= KEEP_OPEN_RST;
			frame_end_bit_count    <= FRAME_END_RST;
		end
		else if (wr)
		begin
			case (cmd_code)
				CMD_DOZE_MODE:
					if (cmd_wdata[15:8] == 8'h00 &&
						(cmd_wdata[7:0] <= DOZE_PIN || is_cyclic(cmd_wdata[7:0])))
						doze_mode_code <= cmd_wdata[7:0];
				CMD_LINE_FUNC:
					if (cmd_wdata <= 16'(LINE_FLOW_CTRL))
						line_function_code <= cmd_wdata[7:0];
				CMD_KEEP_OPEN:
					if (cmd_wdata[15:8] == 8'h00)
						channel_keep_open_time <= cmd_wdata[7:0];
				CMD_FRAME_END:
					if (cmd_wdata <= 16'(FRAME_END_MAX))
						frame_end_bit_count <= cmd_wdata[7:0];
				default:
					;  // Read-only and unknown codes store nothing
			endcase
		end
	end

	// Level of the last received packet, held inside its range
	always_ff @(posedge clock)
	begin
		if (!resetn)
			received_level_read <= RX_LEVEL_RST;
		else if (rx_pkt)
			received_level_read <= clamp_level(rx_level);
	end

	// Command answers, one cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 16'h0;
			rsp_len_r   <= RSP_LEN_NONE;
			rsp_error_r <= 1'b0;
		end
		else
		begin
			rsp_valid_r <= cmd_valid;
			rsp_data_r  <= 16'h0;
			rsp_len_r   <= RSP_LEN_NONE;
			rsp_error_r <= 1'b0;
			if (cmd_valid)
			begin
				case (cmd_code)
					CMD_DOZE_MODE:  rsp_data_r <= {8'h00, doze_mode_code};
					CMD_LINE_FUNC:  rsp_data_r <= {8'h00, line_function_code};
					CMD_KEEP_OPEN:  rsp_data_r <= {8'h00, channel_keep_open_time};
					CMD_FRAME_END:  rsp_data_r <= {8'h00, frame_end_bit_count};
					CMD_RX_LEVEL:   rsp_data_r <= {8'h00, received_level_read};
					CMD_UNIT_UPPER: rsp_data_r <= UNIT_UPPER;
					CMD_UNIT_LOWER: rsp_data_r <= UNIT_LOWER;
					default:        rsp_error_r <= 1'b1;
				endcase
				if (!cmd_write)
				begin
					case (cmd_code)
						CMD_UNIT_UPPER, CMD_UNIT_LOWER: rsp_len_r <= RSP_LEN_WORD;
						CMD_DOZE_MODE, CMD_LINE_FUNC, CMD_KEEP_OPEN,
						CMD_FRAME_END, CMD_RX_LEVEL:    rsp_len_r <= RSP_LEN_BYTE;
						default:                        rsp_len_r <= RSP_LEN_NONE;
					endcase
				end
				else
				begin
					rsp_data_r <= 16'h0;
					case (cmd_code)
						CMD_DOZE_MODE:
							rsp_error_r <= !(cmd_wdata[15:8] == 8'h00 &&
								(cmd_wdata[7:0] <= DOZE_PIN || is_cyclic(cmd_wdata[7:0])));
						CMD_LINE_FUNC: rsp_error_r <= cmd_wdata > 16'(LINE_FLOW_CTRL);
						CMD_KEEP_OPEN: rsp_error_r <= cmd_wdata[15:8] != 8'h00;
						CMD_FRAME_END: rsp_error_r <= cmd_wdata > 16'(FRAME_END_MAX);
						default:       rsp_error_r <= 1'b1;
					endcase
				end
			end
		end
	end

	// Line function and framing decodes
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			bin_prog_en_r  <= 1'b0;
			flow_ctrl_en_r <= 1'b0;
			two_stop_r     <= 1'b0;
		end
		else
		begin
			bin_prog_en_r  <= line_function_code == LINE_BIN_PROG;
			flow_ctrl_en_r <= line_function_code == LINE_FLOW_CTRL;
			two_stop_r     <= frame_end_bit_count[FRAME_END_BIT];
		end
	end

	// Sleep controller
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			RPSB_AWAKE:
				if (doze_mode_code == DOZE_PIN && sleep_pin)
					state_nxt = RPSB_DOZE;
				else if (cyclic && !activity && idle_cnt_r >= idle_delay_before_doze)
					state_nxt = RPSB_DOZE;
			RPSB_DOZE:
				if (doze_mode_code == DOZE_PIN)
					state_nxt = sleep_pin ? RPSB_DOZE : RPSB_AWAKE;
				else if (!cyclic)
					state_nxt = RPSB_AWAKE;
				else if (tick && wake_cnt_r + 8'h1 >= wake_tenths(doze_mode_code))
					state_nxt = RPSB_LISTEN;
			RPSB_LISTEN:
				if (!cyclic)
					state_nxt = RPSB_AWAKE;
				else if (wake_init_seen)
					state_nxt = RPSB_SYNC;
				else if (tick)
					state_nxt = RPSB_DOZE;
			RPSB_SYNC:
				if (!cyclic || wake_init_done)
					state_nxt = RPSB_AWAKE;
			default:
				state_nxt = RPSB_AWAKE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_r     <= RPSB_AWAKE;
			dozing_r    <= 1'b0;
			listening_r <= 1'b0;
			rx_start_r  <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			dozing_r    <= state_nxt == RPSB_DOZE;
			listening_r <= state_nxt == RPSB_LISTEN;
			rx_start_r  <= state_r == RPSB_SYNC && state_nxt == RPSB_AWAKE && cyclic;
		end
	end

	// Idle timer in tenths, only while a cyclic mode is chosen
	always_ff @(posedge clock)
	begin
		if (!resetn || !cyclic || activity || state_r != RPSB_AWAKE)
			idle_cnt_r <= 16'h0;
		else if (tick && idle_cnt_r != 16'hFFFF)
			idle_cnt_r <= idle_cnt_r + 16'h1;
	end

	// Wake period counter while dozing
	always_ff @(posedge clock)
	begin
		if (!resetn || state_r != RPSB_DOZE)
			wake_cnt_r <= 8'h0;
		else if (tick)
			wake_cnt_r <= wake_cnt_r + 8'h1;
	end

	// Channel session hold, reloaded by each data packet
	// One spare unit, so the free-running tick never ends a session early
	always_ff @(posedge clock)
	begin
		if (!resetn)
			sess_cnt_r <= 9'h0;
		else if (tx_pkt || rx_pkt)
			sess_cnt_r <= (channel_keep_open_time == 8'h0) ? 9'h0 :
				{1'h0, channel_keep_open_time} + 9'h1;
		else if (tick && sess_cnt_r != 9'h0)
			sess_cnt_r <= sess_cnt_r - 9'h1;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			session_open_r <= 1'b0;
			include_sync_r <= 1'b1;
		end
		else
		begin
			session_open_r <= sess_cnt_r != 9'h0;
			if (tx_pkt)
				include_sync_r <= channel_keep_open_time == 8'h0 ||
					sess_cnt_r == 9'h0;
		end
	end

	// Checks
	a_level_range: assert property (@(posedge clock) disable iff (!resetn)
		received_level_read >= RX_LEVEL_MIN && received_level_read <= RX_LEVEL_MAX)
		else $error("received level out of range");
	a_line_decode: assert property (@(posedge clock) disable iff (!resetn)
		wr && cmd_code == CMD_LINE_FUNC && cmd_wdata == 16'h0002 |=> ##1 flow_ctrl_en_r
		&& !bin_prog_en_r)
		else $error("flow control not enabled after line code 2");
	a_stop_bits: assert property (@(posedge clock) disable iff (!resetn)
		wr && cmd_code == CMD_FRAME_END && cmd_wdata == 16'h0001 |=> ##1 two_stop_r)
		else $error("two stop bits not selected");
	a_unit_read: assert property (@(posedge clock) disable iff (!resetn)
		cmd_valid && !cmd_write && cmd_code == CMD_UNIT_UPPER |=>
		rsp_valid_r && rsp_data_r == UNIT_UPPER && rsp_len_r == RSP_LEN_WORD)
		else $error("unit number upper word answer wrong");
	a_never_sleep: assert property (@(posedge clock) disable iff (!resetn)
		doze_mode_code == DOZE_NEVER && state_r == RPSB_AWAKE |=> !dozing_r)
		else $error("dozing with sleep disabled");
	a_mode_reset: assert property (@(posedge clock)
		$rose(resetn) |-> doze_mode_code == DOZE_NEVER && !dozing_r)
		else $error("sleep mode not zero after reset");
	a_listen_miss: assert property (@(posedge clock) disable iff (!resetn)
		state_r == RPSB_LISTEN && cyclic && tick && !wake_init_seen |=>
		state_r == RPSB_DOZE && dozing_r)
		else $error("no return to sleep after empty listen");
	a_idle_doze: assert property (@(posedge clock) disable iff (!resetn)
		state_r == RPSB_AWAKE && cyclic && !activity &&
		idle_cnt_r >= idle_delay_before_doze |=> dozing_r)
		else $error("idle delay reached without sleep");
	a_timer_gate: assert property (@(posedge clock) disable iff (!resetn)
		!cyclic |=> idle_cnt_r == 16'h0)
		else $error("idle timer runs outside cyclic sleep");
	a_sync_omit: assert property (@(posedge clock) disable iff (!resetn)
		tx_pkt && channel_keep_open_time != 8'h0 && sess_cnt_r != 9'h0 |=> !include_sync_r)
		else $error("sync sent inside open session");
	a_session_end: assert property (@(posedge clock) disable iff (!resetn)
		sess_cnt_r == 9'h1 && tick && !tx_pkt && !rx_pkt |=> ##1 !session_open_r)
		else $error("session did not expire");
	a_sync_default: assert property (@(posedge clock) disable iff (!resetn)
		tx_pkt && channel_keep_open_time == 8'h0 |=> include_sync_r)
		else $error("sync missing with hold zero");
	a_ro_write: assert property (@(posedge clock) disable iff (!resetn)
		wr && cmd_code == CMD_RX_LEVEL && !rx_pkt |=> $stable(received_level_read)
		&& rsp_error_r)
		else $error("read-only level changed by write");

	c_cyclic_wake:   cover property (@(posedge clock) disable iff (!resetn)
		state_r == RPSB_SYNC ##1 rx_start_r);
	c_listen_miss:   cover property (@(posedge clock) disable iff (!resetn)
		state_r == RPSB_LISTEN ##1 state_r == RPSB_DOZE);
	c_sync_omitted:  cover property (@(posedge clock) disable iff (!resetn)
		tx_pkt ##1 !include_sync_r);
	c_pin_sleep:     cover property (@(posedge clock) disable iff (!resetn)
		doze_mode_code == DOZE_PIN && dozing_r);
endmodule

// File: tb/rpsb_host_model.sv
/*
 * Host model: issues parameter commands on the bank's command port and
 * collects each answer. Assumes one clock shared with the bank.
 */
`timescale 1ns/1ns
module rpsb_host_model
	import rpsb_pkg::*;
(
	input  logic        clock,        // Shared clock
	output logic        cmd_valid,    // Command strobe
	output logic        cmd_write,    // Write select
	output logic [7:0]  cmd_code,     // Command code
	output logic [15:0] cmd_wdata,    // Write value
	input  logic        rsp_valid_r,  // Answer strobe
	input  logic [15:0] rsp_data_r,   // Answer value
	input  logic [1:0]  rsp_len_r,    // Answer byte count
	input  logic        rsp_error_r   // Refusal flag
);
	initial
	begin
		cmd_valid = 1'h0;
		cmd_write = 1'h0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0;
	end

	// One command; answer must land on the first edge waited
	task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] d, output logic [1:0] l, output logic e, output logic ok);
		int i;
		@(posedge clock);
		cmd_valid <= 1'h1;
		cmd_write <= wr;
		cmd_code  <= code;
		cmd_wdata <= wd;
		@(posedge clock);
		cmd_valid <= 1'h0;
		// Released fields show a changed pattern
		cmd_code  <= ~code;
		cmd_wdata <= ~wd;
		ok = 1'h0;
		d = 16'h0;
		l = 2'h0;
		e = 1'h0;
		for (i = 0; i < 4 && !ok; i++)
		begin
			@(posedge clock);
			if (rsp_valid_r === 1'h1)
			begin
				ok = (i == 0);
				d = rsp_data_r;
				l = rsp_len_r;
				e = rsp_error_r;
			end
		end
		// Answer stands one cycle only
		@(posedge clock);
		if (rsp_valid_r !== 1'h0 || rsp_data_r !== 16'h0 || rsp_len_r !== 2'h0)
			ok = 1'h0;
	endtask
endmodule

// File: tb/testbench.sv
/*
 * Self-checking bench for the parameter bank: command table, line and
 * framing decodes, level clamp, session hold, sleep modes, reset.
 * Assumes the tick divider is shortened to T clocks.
 */
`timescale 1ns/1ns
module testbench
	import rpsb_pkg::*;
;
	localparam int          T       = 8;
	localparam logic [15:0] UNIT_HI = 16'hA5C3;  // Arbitrary value
	localparam logic [15:0] UNIT_LO = 16'h3C5A;  // Arbitrary value
	typedef struct {logic wr; logic [7:0] c; logic [15:0] w, d; logic [1:0] l; logic e;} rpsb_row_s;
	logic        clock, resetn, cmd_valid, cmd_write, rx_pkt, tx_pkt, tx_active, rx_active;
	logic        sleep_pin, wake_init_seen, wake_init_done, rsp_valid_r, rsp_error_r;
	logic        bin_prog_en_r, flow_ctrl_en_r, two_stop_r, dozing_r, listening_r;
	logic        rx_start_r, session_open_r, include_sync_r;
	logic [7:0]  cmd_code, rx_level;
	logic [15:0] cmd_wdata, rsp_data_r, idle_delay_before_doze;
	logic [1:0]  rsp_len_r;
	int          bad_count, check_count, i, m, n;
	int          wake_t[6] = '{5, 10, 20, 40, 80, 160};
	logic [7:0]  lv_in[3]  = '{8'h02, 8'h40, 8'h20};
	logic [7:0]  lv_exp[3] = '{8'h06, 8'h36, 8'h20};
	rpsb_row_s   rows[25]  = '{
		'{1'h0, 8'h01, 16'h0, 16'h0, 2'h1, 1'h0}, '{1'h0, 8'h16, 16'h0, 16'h0, 2'h1, 1'h0},
		'{1'h0, 8'h17, 16'h0, 16'h0, 2'h1, 1'h0}, '{1'h0, 8'h36, 16'h0, 16'h0, 2'h1, 1'h0},
		'{1'h0, 8'h1C, 16'h0, 16'h6, 2'h1, 1'h0}, '{1'h0, 8'h25, 16'h0, UNIT_HI, 2'h2, 1'h0},
		'{1'h0, 8'h26, 16'h0, UNIT_LO, 2'h2, 1'h0}, '{1'h1, 8'h16, 16'h2, 16'h0, 2'h0, 1'h0},
		'{1'h1, 8'h16, 16'h3, 16'h0, 2'h0, 1'h1}, '{1'h1, 8'h36, 16'h1, 16'h0, 2'h0, 1'h0},
		'{1'h1, 8'h36, 16'h2, 16'h0, 2'h0, 1'h1}, '{1'h1, 8'h17, 16'hFF, 16'h0, 2'h0, 1'h0},
		'{1'h1, 8'h17, 16'h100, 16'h0, 2'h0, 1'h1}, '{1'h1, 8'h01, 16'h2, 16'h0, 2'h0, 1'h1},
		'{1'h1, 8'h01, 16'h9, 16'h0, 2'h0, 1'h1}, '{1'h1, 8'h1C, 16'h5, 16'h0, 2'h0, 1'h1},
		'{1'h1, 8'h25, 16'h1, 16'h0, 2'h0, 1'h1}, '{1'h1, 8'h26, 16'h1, 16'h0, 2'h0, 1'h1},
		'{1'h1, 8'h22, 16'h0, 16'h0, 2'h0, 1'h1}, '{1'h0, 8'h22, 16'h0, 16'h0, 2'h0, 1'h1},
		'{1'h0, 8'h16, 16'h0, 16'h2, 2'h1, 1'h0}, '{1'h0, 8'h36, 16'h0, 16'h1, 2'h1, 1'h0},
		'{1'h0, 8'h17, 16'h0, 16'hFF, 2'h1, 1'h0}, '{1'h0, 8'h25, 16'h0, UNIT_HI, 2'h2, 1'h0},
		'{1'h0, 8'h1C, 16'h0, 16'h6, 2'h1, 1'h0}};

	rpsb_bank #(.TICK_CYCLES(T), .UNIT_UPPER(UNIT_HI), .UNIT_LOWER(UNIT_LO)) dut_u (.*);
	rpsb_host_model host_u (.*);

	initial
	begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	task automatic print_verdict();
		$display("Counts: %0d checks, %0d mismatches", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] w,
		input logic [15:0] ed, input logic [1:0] el, input logic ee);
		logic [15:0] d;
		logic [1:0]  l;
		logic        e;
		logic        ok;
		host_u.send(wr, c, w, d, l, e, ok);
		chk({15'h0, ok}, 16'h1);
		chk(d, ed);
		chk({14'h0, l}, {14'h0, el});
		chk({15'h0, e}, {15'h0, ee});
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return dozing_r;
			1: return listening_r;
			2: return session_open_r;
			default: return rx_start_r;
		endcase
	endfunction

	// Bounded wait for an output level; counts edges waited
	task automatic wait_for(input int k, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (sig(k) !== lvl && cnt < lim)
		begin
			@(posedge clock);
			cnt++;
		end
		if (sig(k) !== lvl)
		begin
			chk({15'h0, sig(k)}, {15'h0, lvl});
			print_verdict();
		end
	endtask

	task automatic pulse_tx();
		@(posedge clock);
		tx_pkt <= 1'h1;
		@(posedge clock);
		tx_pkt <= 1'h0;
		@(posedge clock);
	endtask

	initial
	begin
		repeat (100000) @(posedge clock);
		bad_count++;
		$display("CHECK FAILED at %0t run limit seen %h expected %h", $time, 1'h1, 1'h0);
		print_verdict();
	end

	initial
	begin
		{resetn, rx_pkt, tx_pkt, tx_active, rx_active, sleep_pin} = 6'h0;
		{wake_init_seen, wake_init_done} = 2'h0;
		rx_level = 8'h00;
		idle_delay_before_doze = 16'h0;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(posedge clock);
		resetn <= 1'h1;
		@(posedge clock);
		chk(include_sync_r, 1'h1);
		chk(dozing_r, 1'h0);
		chk({bin_prog_en_r, flow_ctrl_en_r}, 2'h0);
		chk(two_stop_r, 1'h0);
		chk(session_open_r, 1'h0);
		$display("Test reset state done");
		for (i = 0; i < 25; i++)
			cmd(rows[i].wr, rows[i].c, rows[i].w, rows[i].d, rows[i].l, rows[i].e);
		@(posedge clock);
		chk({bin_prog_en_r, flow_ctrl_en_r}, 2'h1);
		chk(two_stop_r, 1'h1);
		cmd(1'h1, 8'h16, 16'h1, 16'h0, 2'h0, 1'h0);
		@(posedge clock);
		chk({bin_prog_en_r, flow_ctrl_en_r}, 2'h2);
		cmd(1'h1, 8'h36, 16'h0, 16'h0, 2'h0, 1'h0);
		@(posedge clock);
		chk(two_stop_r, 1'h0);
		$display("Test command table done");
		// Hold two units, one above the send gap
		cmd(1'h1, 8'h17, 16'h2, 16'h0, 2'h0, 1'h0);
		pulse_tx();
		chk(include_sync_r, 1'h1);
		@(posedge clock);
		chk(session_open_r, 1'h1);
		pulse_tx();
		chk(include_sync_r, 1'h0);
		wait_for(2, 1'h0, 3 * T + 4, n);
		chk(n >= 2 * T, 1'h1);
		pulse_tx();
		chk(include_sync_r, 1'h1);
		cmd(1'h1, 8'h17, 16'h0, 16'h0, 2'h0, 1'h0);
		pulse_tx();
		pulse_tx();
		chk(include_sync_r, 1'h1);
		$display("Test session hold done");
		for (i = 0; i < 3; i++)
		begin
			@(posedge clock);
			rx_pkt <= 1'h1;
			rx_level <= lv_in[i];
			@(posedge clock);
			rx_pkt <= 1'h0;
			rx_level <= ~lv_in[i];
			cmd(1'h0, 8'h1C, 16'h0, {8'h0, lv_exp[i]}, 2'h1, 1'h0);
		end
		$display("Test received level done");
		repeat (3 * T) @(posedge clock);
		chk(dozing_r, 1'h0);
		cmd(1'h1, 8'h01, 16'h1, 16'h0, 2'h0, 1'h0);
		sleep_pin <= 1'h1;
		wait_for(0, 1'h1, 4, n);
		sleep_pin <= 1'h0;
		wait_for(0, 1'h0, 4, n);
		for (m = 3; m <= 9; m++)
		begin
			cmd(1'h1, 8'h01, 16'h0, 16'h0, 2'h0, 1'h0);
			tx_active <= 1'h1;
			idle_delay_before_doze <= 16'h2;
			cmd(1'h1, 8'h01, (m > 8) ? 16'h3 : m[15:0], 16'h0, 2'h0, 1'h0);
			repeat (3 * T) @(posedge clock);
			chk(dozing_r, 1'h0);
			tx_active <= 1'h0;
			wait_for(0, 1'h1, 3 * T + 4, n);
			chk(n >= T, 1'h1);
			if (m > 8)
				break;
			wait_for(1, 1'h1, (wake_t[m - 3] + 1) * T + 4, n);
			chk(n >= (wake_t[m - 3] - 1) * T, 1'h1);
			wait_for(1, 1'h0, T + 4, n);
			wait_for(0, 1'h1, 4, n);
		end
		wait_for(1, 1'h1, 6 * T + 4, n);
		wake_init_seen <= 1'h1;
		@(posedge clock);
		wake_init_seen <= 1'h0;
		wake_init_done <= 1'h1;
		@(posedge clock);
		wake_init_done <= 1'h0;
		wait_for(3, 1'h1, 4, n);
		@(posedge clock);
		chk(dozing_r, 1'h0);
		cmd(1'h1, 8'h01, 16'h1, 16'h0, 2'h0, 1'h0);
		cmd(1'h1, 8'h17, 16'h5, 16'h0, 2'h0, 1'h0);
		$display("Test sleep modes done");
		resetn <= 1'h0;
		repeat (16) @(posedge clock);
		resetn <= 1'h1;
		cmd(1'h0, 8'h01, 16'h0, 16'h0, 2'h1, 1'h0);
		cmd(1'h0, 8'h17, 16'h0, 16'h0, 2'h1, 1'h0);
		cmd(1'h0, 8'h16, 16'h0, 16'h0, 2'h1, 1'h0);
		$display("Test second reset done");
		print_verdict();
	end
endmodule
